/* rtl/host_port_pkg.sv */
// Shared constants and carrier types for the decoder host port
package host_port_pkg;

  // ==========================================
  // Bus geometry
  localparam int DATA_W = 16;
  localparam int ADDR_W = 18;
  localparam int REG_ADDR_W = 12;
  localparam int REG_ADDR_LSB = 0;
  localparam int MEM_ADDR_W = ADDR_W;

  // ==========================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACCESS_LAT_NS = 8;
  localparam int ACCESS_LAT_CYC =
    ((ACCESS_LAT_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================
  // Reset values
  localparam logic [DATA_W-1:0] RD_DATA_RST = 16'h0000;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic register_select_n;
    logic memory_select_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
    logic read_not_write;
  } host_ctl_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
    logic [1:0] lanes;
    logic is_mem;
    logic is_write;
  } access_s;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_TRANSPARENT,
    MODE_DEBUG
  } port_mode_e;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
    lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction : lane_mask

endpackage : host_port_pkg

/* rtl/port_delay_timer.sv */
// Access latency counter for one host bus cycle
`timescale 1ns/1ps
module port_delay_timer
  import host_port_pkg::*;
#(
  parameter int CYCLES = ACCESS_LAT_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_sys_rst, // Async reset, high
  input wire logic i_start, // Restart pulse
  input wire logic i_run, // Count while high
  output logic o_done // High once count elapsed
);
  initial begin
    if (CYCLES < 1 || CYCLES > 255) begin
      $error("port_delay_timer: CYCLES out of range");
    end
  end

  logic [7:0] count_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_reg <= 8'h00;
      o_done <= 1'b0;
    end else if (i_start || !i_run) begin
      count_reg <= 8'h00;
      o_done <= 1'b0;
    end else if (count_reg == 8'(CYCLES - 1)) begin
      o_done <= 1'b1;
    end else begin
      count_reg <= count_reg + 8'h01;
    end
  end
endmodule : port_delay_timer

/* rtl/port_read_latch.sv */
// Byte-lane read data holding register
`timescale 1ns/1ps
module port_read_latch
  import host_port_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_sys_rst, // Async reset, high
  input wire logic i_load, // Capture strobe
  input wire logic [1:0] i_lanes, // Lanes to capture
  input wire logic [DATA_W-1:0] i_data, // Data in
  output logic [DATA_W-1:0] o_data // Held data
);
  logic [DATA_W-1:0] m;
  assign m = lane_mask(i_lanes);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= RD_DATA_RST;
    end else if (i_load) begin
      o_data <= (i_data & m) | (o_data & ~m);
    end
  end
endmodule : port_read_latch

/* rtl/video_decoder_host_port.sv */
// Host bus, interrupt and DMA handshake port of the video decoder
`timescale 1ns/1ps
module video_decoder_host_port
  import host_port_pkg::*;
(
  input wire logic i_clk, // System clock, 250 MHz
  input wire logic i_sys_rst, // Async reset, high
  input wire logic [ADDR_W:1] i_addr, // Host address A18..A1
  input wire logic [DATA_W-1:0] i_data, // Host data bus input
  output logic [DATA_W-1:0] o_data, // Host data bus output
  output logic [1:0] o_data_oe, // Per-lane data drive enable
  input wire host_ctl_s i_ctl, // Selects, strobes, direction
  input wire logic i_transfer_ack_n, // Ack pin input (DMA side)
  output logic o_transfer_ack_n, // Ack pin output
  output logic o_transfer_ack_oe, // Ack pin drive enable
  output logic o_irq_n, // Interrupt pin output, always low
  output logic o_irq_oe, // Interrupt pin pull-down enable
  input wire logic i_irq_acknowledge_n, // Interrupt acknowledge
  output logic o_dma_req_n, // DMA request output, always low
  output logic o_dma_req_oe, // DMA request pull-down enable
  input wire logic i_dma_ack_n, // DMA grant
  output logic o_dma_ready_n, // DMA ready output
  output logic o_dma_ready_oe, // DMA ready drive enable
  input wire logic i_dma_done_n, // Last DMA transfer marker
  input wire logic i_dma_abort_n, // DMA abort
  input wire port_mode_e i_mode, // Current port mode
  input wire logic i_irq_event, // Internal interrupt pulse
  input wire logic i_dma_start, // Internal pulse: begin stream request
  output access_s o_access, // Captured access to core
  output logic o_access_valid, // One-cycle pulse with o_access
  input wire logic [DATA_W-1:0] i_rd_data, // Read data from core
  output logic [DATA_W-1:0] o_dma_data, // Captured DMA word
  output logic o_dma_valid, // One-cycle pulse with DMA word
  output logic o_irq_pending // Interrupt waiting for acknowledge
);

  // ==========================================
  // Access decode
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_WAIT,
    BUS_ACK,
    BUS_END
  } bus_state_e;

  bus_state_e bus_reg;
  bus_state_e bus_next;
  logic [1:0] lanes;
  logic reg_sel;
  logic mem_sel;
  logic mem_ok;
  logic any_sel;
  logic strobe_any;
  logic timer_done;
  logic [DATA_W-1:0] rd_held;
  logic rd_load;
  logic dma_active;

  assign lanes = {~i_ctl.upper_byte_strobe_n, ~i_ctl.lower_byte_strobe_n};
  assign strobe_any = |lanes;
  assign mem_ok = (i_mode == MODE_TRANSPARENT) || (i_mode == MODE_DEBUG);
  assign reg_sel = !i_ctl.register_select_n;
  assign mem_sel = !i_ctl.memory_select_n && mem_ok;
  assign any_sel = (reg_sel || mem_sel) && !dma_active;

  // ==========================================
  // Host cycle state machine
  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      BUS_IDLE: begin
        if (any_sel && strobe_any) begin
          bus_next = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        if (!(any_sel && strobe_any)) begin
          bus_next = BUS_IDLE;
        end else if (timer_done) begin
          bus_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        if (!(any_sel && strobe_any)) begin
          bus_next = BUS_END;
        end
      end
      BUS_END: begin
        bus_next = BUS_IDLE;
      end
      default: begin
        bus_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus_reg <= BUS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  port_delay_timer #(
    .CYCLES(ACCESS_LAT_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(bus_reg == BUS_IDLE),
    .i_run(bus_reg == BUS_WAIT),
    .o_done(timer_done)
  );

  // Read data comes from core while waiting; lanes taken as strobed
  assign rd_load = (bus_reg == BUS_WAIT) && timer_done && i_ctl.read_not_write;

  port_read_latch u_rd (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(rd_load),
    .i_lanes(lanes),
    .i_data(i_rd_data),
    .o_data(rd_held)
  );

  // ==========================================
  // Access capture toward the core
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_access <= '0;
      o_access_valid <= 1'b0;
    end else begin
      o_access_valid <= 1'b0;
      if (bus_reg == BUS_IDLE && any_sel && strobe_any) begin
        o_access.is_mem <= !reg_sel;
        o_access.is_write <= !i_ctl.read_not_write;
        o_access.lanes <= lanes;
        o_access.data <= i_data & lane_mask(lanes);
        if (reg_sel) begin
          // High address lines are don't-care for registers
          o_access.addr <= {6'h00, i_addr[REG_ADDR_W:1]};
        end else begin
          o_access.addr <= i_addr;
        end
        o_access_valid <= 1'b1;
      end
    end
  end

  // ==========================================
  // Acknowledge and data drive
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_transfer_ack_n <= 1'b1;
      o_transfer_ack_oe <= 1'b0;
      o_data <= RD_DATA_RST;
      o_data_oe <= 2'b00;
    end else begin
      if (bus_next == BUS_ACK) begin
        // Write data was captured at entry, read data sits in the latch
        o_transfer_ack_n <= 1'b0;
        o_transfer_ack_oe <= 1'b1;
      end else if (bus_next == BUS_END) begin
        // Drive high one cycle for a fast edge before release
        o_transfer_ack_n <= 1'b1;
        o_transfer_ack_oe <= 1'b1;
      end else begin
        o_transfer_ack_n <= 1'b1;
        o_transfer_ack_oe <= 1'b0;
      end
      if ((bus_reg == BUS_WAIT || bus_reg == BUS_ACK) && (bus_next != BUS_IDLE) &&
          (bus_next != BUS_END) && i_ctl.read_not_write &&
          (timer_done || bus_reg == BUS_ACK)) begin
        o_data <= (bus_reg == BUS_ACK) ? rd_held : i_rd_data;
        o_data_oe <= lanes;
      end else begin
        o_data_oe <= 2'b00;
      end
    end
  end

  // ==========================================
  // Interrupt request
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_pending <= 1'b0;
      o_irq_oe <= 1'b0;
      o_irq_n <= 1'b0;
    end else begin
      // New event wins over an acknowledge in the same cycle
      if (i_irq_event) begin
        o_irq_pending <= 1'b1;
        o_irq_oe <= 1'b1;
      end else if (!i_irq_acknowledge_n) begin
        o_irq_pending <= 1'b0;
        o_irq_oe <= 1'b0;
      end
      o_irq_n <= 1'b0;
    end
  end

  // ==========================================
  // DMA stream handshake
  logic dma_req_reg;
  logic dma_last_reg;
  logic ack_seen_reg;

  assign dma_active = !i_dma_ack_n;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dma_req_reg <= 1'b0;
      dma_last_reg <= 1'b0;
      o_dma_req_oe <= 1'b0;
      o_dma_req_n <= 1'b0;
    end else begin
      o_dma_req_n <= 1'b0;
      if (!i_dma_abort_n) begin
        dma_req_reg <= 1'b0;
        dma_last_reg <= 1'b0;
        o_dma_req_oe <= 1'b0;
      end else if (!i_dma_done_n) begin
        dma_req_reg <= 1'b0;
        dma_last_reg <= 1'b1;
        o_dma_req_oe <= 1'b0;
      end else if (i_dma_start) begin
        dma_req_reg <= 1'b1;
        dma_last_reg <= 1'b0;
        o_dma_req_oe <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_seen_reg <= 1'b0;
      o_dma_data <= RD_DATA_RST;
      o_dma_valid <= 1'b0;
      o_dma_ready_n <= 1'b1;
      o_dma_ready_oe <= 1'b0;
    end else begin
      o_dma_valid <= 1'b0;
      if (!i_dma_abort_n || i_dma_ack_n) begin
        ack_seen_reg <= 1'b0;
        o_dma_ready_n <= 1'b1;
        o_dma_ready_oe <= 1'b0;
      end else if (!i_transfer_ack_n && !ack_seen_reg) begin
        o_dma_data <= i_data;
        o_dma_valid <= 1'b1;
        ack_seen_reg <= 1'b1;
        o_dma_ready_n <= 1'b0;
        o_dma_ready_oe <= 1'b1;
      end else if (i_transfer_ack_n) begin
        ack_seen_reg <= 1'b0;
        o_dma_ready_n <= 1'b1;
        o_dma_ready_oe <= 1'b0;
      end
    end
  end

endmodule : video_decoder_host_port

/* tb/video_decoder_host_port_assertions.sv */
// Port assertions for the decoder host port
`timescale 1ns/1ps
module video_decoder_host_port_assertions
  import host_port_pkg::*;
(
  input wire logic i_clk, // in
  input wire logic i_sys_rst, // in
  input wire logic [ADDR_W:1] i_addr, // in
  input wire logic [DATA_W-1:0] i_data, // in
  input wire host_ctl_s i_ctl, // in
  input wire logic i_transfer_ack_n, // in
  input wire port_mode_e i_mode, // in
  input wire logic i_dma_ack_n, // in
  input wire logic [1:0] o_data_oe, // out
  input wire logic o_transfer_ack_n, // out
  input wire logic o_transfer_ack_oe, // out
  input wire logic o_irq_n, // out
  input wire logic o_dma_req_n, // out
  input wire logic o_dma_ready_n, // out
  input wire logic o_dma_ready_oe, // out
  input wire access_s o_access, // out
  input wire logic o_access_valid, // out
  input wire logic [DATA_W-1:0] o_dma_data, // out
  input wire logic o_dma_valid // out
);
  // ==========================================
  // Properties
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_irq_open_drain: assert property (o_irq_n == 1'b0)
    else $error("interrupt pin driven high");
  a_req_open_drain: assert property (o_dma_req_n == 1'b0)
    else $error("request pin driven high");
  a_ready_tri_state: assert property (o_dma_ready_oe |-> !o_dma_ready_n)
    else $error("ready driven while inactive");
  a_dma_word_capture: assert property (o_dma_valid |-> $past(!i_dma_ack_n && !i_transfer_ack_n)
    && o_dma_data == $past(i_data))
    else $error("dma word not taken from qualified bus");
  a_data_read_only: assert property (|o_data_oe |-> $past(i_ctl.read_not_write))
    else $error("data bus driven outside a read");
  a_upper_lane_drive: assert property (o_data_oe[1] |-> !$past(i_ctl.upper_byte_strobe_n))
    else $error("upper lane driven without strobe");
  a_ack_after_wait: assert property ($rose(!o_transfer_ack_n && o_transfer_ack_oe)
    |-> $past(o_access_valid, 3))
    else $error("acknowledge not three cycles after capture");
  a_ack_release_seq: assert property ((o_transfer_ack_oe && !o_transfer_ack_n
    && i_ctl.upper_byte_strobe_n && i_ctl.lower_byte_strobe_n)
    |=> (o_transfer_ack_n && o_transfer_ack_oe) ##1 !o_transfer_ack_oe)
    else $error("acknowledge not released after cycle end");
  a_reg_addr_window: assert property (o_access_valid && !o_access.is_mem
    |-> o_access.addr == {6'h00, $past(i_addr[12:1])})
    else $error("register address not cut to low twelve lines");
  a_mem_sel_refused: assert property (o_access_valid
    |-> !$past(i_ctl.register_select_n) || $past(i_mode) != MODE_NORMAL)
    else $error("memory access taken in normal mode");

  c_write: cover property (o_access_valid && o_access.is_write);
  c_read: cover property (o_access_valid && !o_access.is_write);
  c_dma: cover property (o_dma_valid);
endmodule : video_decoder_host_port_assertions

bind video_decoder_host_port video_decoder_host_port_assertions u_chk (
  .i_clk, .i_sys_rst, .i_addr, .i_data, .i_ctl, .i_transfer_ack_n, .i_mode, .i_dma_ack_n,
  .o_data_oe, .o_transfer_ack_n, .o_transfer_ack_oe, .o_irq_n, .o_dma_req_n,
  .o_dma_ready_n, .o_dma_ready_oe, .o_access, .o_access_valid, .o_dma_data, .o_dma_valid
);

/* tb/dma_ctrl_model.sv */
// External DMA controller model, one word per grant
`timescale 1ns/1ps
module dma_ctrl_model (
  input wire logic i_clk, // Clock
  input wire logic i_req_n, // Resolved request wire
  input wire logic i_ready_n, // Resolved ready wire
  input wire logic i_go, // Bench permits a word
  input wire logic [3:0] i_stall, // Cycles before data
  input wire logic [15:0] i_word, // Word to send
  output logic o_dma_ack_n = 1'b1, // Grant
  output logic o_transfer_ack_n = 1'b1, // Data qualifier
  output logic [15:0] o_data = 16'h0000, // Bus value
  output logic o_drive = 1'b0 // Bus driven
);
  // ==========================================
  // Transfer
  always begin
    @(negedge i_clk);
    if (i_go && !i_req_n) begin
      o_dma_ack_n = 1'b0;
      repeat (i_stall) @(negedge i_clk);
      o_data = i_word;
      o_drive = 1'b1;
      o_transfer_ack_n = 1'b0;
      do @(negedge i_clk); while (i_ready_n !== 1'b0);
      @(posedge i_clk);
      @(negedge i_clk);
      o_transfer_ack_n = 1'b1;
      o_dma_ack_n = 1'b1;
      o_drive = 1'b0;
      // Released bus must not look like the last word
      o_data = ~o_data;
    end
  end
endmodule : dma_ctrl_model

/* tb/video_decoder_host_port_bench.sv */
// Self-checking bench for the decoder host port
`timescale 1ns/1ps
module video_decoder_host_port_bench;
  import host_port_pkg::*;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_irq_acknowledge_n = 1'b1, i_dma_ack_n;
  logic i_dma_done_n = 1'b1, i_dma_abort_n = 1'b1, i_irq_event = 1'b0, i_dma_start = 1'b0;
  logic [ADDR_W:1] i_addr = '0;
  logic [DATA_W-1:0] host_data = '0, i_rd_data = '0, o_data, o_dma_data, pm_bus, i_data;
  logic [DATA_W-1:0] pm_word = '0, rd_seen;
  host_ctl_s i_ctl = 5'h1F;
  port_mode_e i_mode = MODE_NORMAL;
  logic [1:0] o_data_oe, oe_seen;
  logic o_transfer_ack_n, o_transfer_ack_oe, o_irq_n, o_irq_oe, o_dma_req_n, o_dma_req_oe;
  logic o_dma_ready_n, o_dma_ready_oe, o_access_valid, o_dma_valid, o_irq_pending;
  logic pm_tack_n, pm_drive, pm_go = 1'b0, acked, tack_pin, req_wire, ready_wire;
  logic [3:0] pm_stall = 4'h0;
  access_s o_access, acc;
  int err_total = 0, tests_run = 0, lat, cyc = 0;

  // Pull-ups on the request and ready wires; ack pin and data bus resolved between drivers
  assign req_wire = o_dma_req_oe ? o_dma_req_n : 1'b1;
  assign ready_wire = o_dma_ready_oe ? o_dma_ready_n : 1'b1;
  assign tack_pin = o_transfer_ack_oe ? o_transfer_ack_n : pm_tack_n;
  assign i_data = pm_drive ? pm_bus : host_data;

  video_decoder_host_port u_dut (.i_clk, .i_sys_rst, .i_addr, .i_data, .o_data, .o_data_oe,
    .i_ctl, .i_transfer_ack_n(tack_pin), .o_transfer_ack_n, .o_transfer_ack_oe, .o_irq_n,
    .o_irq_oe, .i_irq_acknowledge_n, .o_dma_req_n, .o_dma_req_oe, .i_dma_ack_n, .o_dma_ready_n,
    .o_dma_ready_oe, .i_dma_done_n, .i_dma_abort_n, .i_mode, .i_irq_event, .i_dma_start,
    .o_access, .o_access_valid, .i_rd_data, .o_dma_data, .o_dma_valid, .o_irq_pending);
  dma_ctrl_model u_dma (.i_clk, .i_req_n(req_wire), .i_ready_n(ready_wire), .i_go(pm_go),
    .i_stall(pm_stall), .i_word(pm_word), .o_dma_ack_n(i_dma_ack_n),
    .o_transfer_ack_n(pm_tack_n), .o_data(pm_bus), .o_drive(pm_drive));

  always #2 i_clk = ~i_clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ==========================================
  // Host bus cycle, held until acknowledge or refusal
  task automatic host_cycle(input logic mem, input logic rnw, input logic [1:0] ln,
                            input logic [18:1] a, input logic [15:0] d);
    @(negedge i_clk);
    acc = '0;
    acked = 1'b0;
    lat = 0;
    i_addr = a;
    host_data = d;
    i_ctl = host_ctl_s'({mem, !mem, !ln[1], !ln[0], rnw});
    while (!acked && lat < 8) begin
      @(negedge i_clk);
      lat++;
      if (o_access_valid === 1'b1) acc = o_access;
      acked = (o_transfer_ack_oe === 1'b1 && o_transfer_ack_n === 1'b0);
    end
    rd_seen = o_data;
    oe_seen = o_data_oe;
    i_ctl = host_ctl_s'({4'hF, rnw});
    host_data = ~d;
    repeat (2) @(negedge i_clk);
    check("ack_released", 2'h0, {o_transfer_ack_oe, 1'b0});
    check("data_released", 2'h0, o_data_oe);
  endtask : host_cycle

  // ==========================================
  // Scenarios
  task automatic sc_host_access();
    host_cycle(1'b0, 1'b0, 2'h3, 18'h3F123, 16'h5AC3);
    check("write_latency", 4, lat);
    check("reg_addr", 18'h00123, acc.addr);
    check("write_data", 16'h5AC3, acc.data);
    check("write_kind", 2'h1, {acc.is_mem, acc.is_write});
    for (int i = 1; i < 3; i++) begin
      host_cycle(1'b0, 1'b0, i[1:0], 18'h00010, 16'hA55A);
      check("lane_data", {{8{i[1]}}, {8{i[0]}}} & 16'hA55A, acc.data);
      check("lane_set", i[1:0], acc.lanes);
    end
    i_rd_data = 16'hC3E1;
    host_cycle(1'b0, 1'b1, 2'h1, 18'h00020, 16'h0000);
    check("read_ack", 1'b1, acked);
    check("read_lanes", 2'h1, oe_seen);
    check("read_byte", 8'hE1, rd_seen[7:0]);
  endtask : sc_host_access

  task automatic sc_mem_modes();
    for (int m = 0; m < 3; m++) begin
      i_mode = port_mode_e'(m);
      host_cycle(1'b1, 1'b0, 2'h3, 18'h2ABCD, 16'h1234);
      check("mem_ack", m != 0, acked);
      check("mem_addr", (m != 0) ? 18'h2ABCD : 18'h00000, acc.addr);
    end
    i_mode = MODE_NORMAL;
  endtask : sc_mem_modes

  task automatic dma_send(input logic [15:0] w, input logic [3:0] st);
    int n;
    n = 0;
    pm_word = w;
    pm_stall = st;
    pm_go = 1'b1;
    // Step past the pulse of the previous word before looking
    do begin
      @(negedge i_clk);
      n++;
    end while (o_dma_valid !== 1'b1 && n < 16);
    pm_go = 1'b0;
    check("dma_word", w, o_dma_data);
  endtask : dma_send

  task automatic dma_begin();
    @(negedge i_clk);
    i_dma_start = 1'b1;
    @(negedge i_clk);
    i_dma_start = 1'b0;
    @(negedge i_clk);
    check("req_pulled", 1'b0, req_wire);
  endtask : dma_begin

  task automatic sc_dma();
    dma_begin();
    dma_send(16'h1357, 4'h0);
    dma_send(16'hBEEF, 4'h3);
    repeat (4) @(negedge i_clk);
    check("ready_idle", 1'b0, o_dma_ready_oe);
    i_dma_done_n = 1'b0;
    @(negedge i_clk);
    i_dma_done_n = 1'b1;
    check("req_done", 1'b1, req_wire);
    dma_begin();
    i_dma_abort_n = 1'b0;
    @(negedge i_clk);
    i_dma_abort_n = 1'b1;
    check("req_abort", 2'h2, {req_wire, o_dma_ready_oe});
  endtask : sc_dma

  task automatic sc_irq();
    @(negedge i_clk);
    i_irq_event = 1'b1;
    @(negedge i_clk);
    i_irq_event = 1'b0;
    check("irq_raised", 2'h3, {o_irq_oe, o_irq_pending});
    i_irq_acknowledge_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_irq_acknowledge_n = 1'b1;
    check("irq_cleared", 2'h0, {o_irq_oe, o_irq_pending});
  endtask : sc_irq

  initial begin
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    sc_host_access();
    sc_mem_modes();
    sc_dma();
    sc_irq();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end
endmodule : video_decoder_host_port_bench
